// ==== logic/icw_consts.svh ====
`ifndef ICW_CONSTS_SVH
`define ICW_CONSTS_SVH
`define ICW_REG_W        32
`define ICW_BYTE_W       8
`define ICW_MAX_REGS     16
`define ICW_BANK_BYTES   128
`define ICW_BANK_ADDR_W  7
`define ICW_WORD_BYTES   4
`define ICW_DEF_DATA_W   32
`define ICW_DEF_NUM_CIDS 4
`define ICW_DEF_NUM_REGS 16
`define ICW_RESET_WORD   32'h0000_0000
`endif

// ==== logic/icw_pkg.sv ====
package icw_pkg;
  typedef enum logic [1:0] {
    ICW_ST_IDLE  = 2'b01,
    ICW_ST_WROTE = 2'b10
  } icw_state_t;
endpackage

// ==== logic/icw_lane.sv ====
`timescale 1ns/100ps
`include "icw_consts.svh"
// one 32-bit register: byte-swapped store under byte enables
module icw_lane (
  input  wire logic                  i_clock,
  input  wire logic                  i_rstn,
  input  wire logic                  i_we,
  input  wire logic [3:0]            i_be,
  input  wire logic [31:0]           i_data,
  output logic      [31:0]           o_value
);
  typedef struct packed {
    logic [31:0] word;
  } icw_lane_st_t;
  icw_lane_st_t cur_ff;
  icw_lane_st_t nxt_cur;
  always_comb begin
    nxt_cur = cur_ff;
    if (i_we) begin
      for (int b = 0; b < 4; b++) begin
        // data byte b lands in register byte 3-b
        if (i_be[b]) begin
          nxt_cur.word[(3-b)*8 +: 8] = i_data[b*8 +: 8];
        end
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cur_ff <= '{word: `ICW_RESET_WORD};
    end else begin
      cur_ff <= nxt_cur;
    end
  end
  assign o_value = cur_ff.word;
endmodule

// ==== logic/icw_write_port.sv ====
`timescale 1ns/100ps
`include "icw_consts.svh"
module icw_write_port
  import icw_pkg::*;
#(
  parameter int DATA_W   = `ICW_DEF_DATA_W,
  parameter int NUM_CIDS = `ICW_DEF_NUM_CIDS,
  parameter int NUM_REGS = `ICW_DEF_NUM_REGS,
  parameter bit HAS_REGS = 1'b1,
  localparam int LANES   = DATA_W / `ICW_REG_W,
  localparam int CIDW    = (NUM_CIDS > 1) ? $clog2(NUM_CIDS) : 1,
  localparam int WADDR_W = `ICW_BANK_ADDR_W - $clog2(DATA_W / `ICW_BYTE_W),
  localparam int ADDR_W  = CIDW + WADDR_W,
  localparam int RD_W    = $clog2(`ICW_MAX_REGS)
) (
  input  wire logic                  I_CLOCK,
  input  wire logic                  I_RSTN,
  input  wire logic [ADDR_W-1:0]     I_ADDRESS,
  input  wire logic                  I_WRITE,
  input  wire logic [DATA_W/8-1:0]   I_BYTEENABLE,
  input  wire logic [DATA_W-1:0]     I_WRITEDATA,
  input  wire logic [CIDW-1:0]       I_RD_CID,
  input  wire logic [RD_W-1:0]       I_RD_INDEX,
  output logic      [31:0]           O_RD_WORD,
  output logic                       O_WRITE_SEEN,
  output logic                       O_WRITE_DROPPED
);
  // wait request is absent by design: every strobe cycle is a write
  typedef struct packed {
    logic [31:0]  rd_word;
    logic         seen;
    logic         dropped;
    icw_state_t   state;
  } icw_top_st_t;

  icw_top_st_t cur_ff;
  icw_top_st_t nxt_cur;

  logic [CIDW-1:0]    cid;
  logic [WADDR_W-1:0] widx;
  logic               in_range;
  logic [31:0]        regs [NUM_CIDS][NUM_REGS];

  // split address into bank select and word index
  assign cid  = I_ADDRESS[ADDR_W-1 -: CIDW];
  assign widx = I_ADDRESS[WADDR_W-1:0];
  // group base beyond configured registers drops the write
  assign in_range = ((32'(widx) * LANES) < NUM_REGS) &&
                    (32'(cid) < NUM_CIDS);

  generate
    if (HAS_REGS) begin : g_regs
      for (genvar c = 0; c < NUM_CIDS; c++) begin : g_cid
        for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
          // lane l of the bus feeds register base+LANES-1-l
          localparam int L = LANES - 1 - (r % LANES);
          logic we;
          // strobe, in-range check and bank and word decode qualify the data
          assign we = I_WRITE && in_range && (32'(cid) == c) &&
                      (32'(widx) == (r / LANES));
          icw_lane u_lane (
            .i_clock (I_CLOCK),
            .i_rstn  (I_RSTN),
            .i_we    (we),
            .i_be    (I_BYTEENABLE[L*4 +: 4]),
            .i_data  (I_WRITEDATA[L*32 +: 32]),
            .o_value (regs[c][r])
          );
        end
      end
    end else begin : g_none
      for (genvar c = 0; c < NUM_CIDS; c++) begin : g_cid
        for (genvar r = 0; r < NUM_REGS; r++) begin : g_reg
          assign regs[c][r] = `ICW_RESET_WORD;
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.seen    = 1'b0;
    nxt_cur.dropped = 1'b0;
    // full-word read for the core side only
    if ((32'(I_RD_CID) < NUM_CIDS) && (32'(I_RD_INDEX) < NUM_REGS)) begin
      nxt_cur.rd_word = regs[I_RD_CID][I_RD_INDEX];
    end else begin
      nxt_cur.rd_word = `ICW_RESET_WORD;
    end
    case (cur_ff.state)
      ICW_ST_IDLE, ICW_ST_WROTE: begin
        if (I_WRITE && HAS_REGS) begin
          nxt_cur.seen    = in_range;
          nxt_cur.dropped = !in_range;
          nxt_cur.state   = ICW_ST_WROTE;
        end else begin
          nxt_cur.state   = ICW_ST_IDLE;
        end
      end
      default: begin
        nxt_cur.state = ICW_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cur_ff <= '{rd_word: `ICW_RESET_WORD, seen: 1'b0, dropped: 1'b0,
                  state: ICW_ST_IDLE};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign O_RD_WORD       = cur_ff.rd_word;
  assign O_WRITE_SEEN    = cur_ff.seen;
  assign O_WRITE_DROPPED = cur_ff.dropped;
endmodule

// ==== tb/icw_mst.sv ====
`timescale 1ns/100ps
module icw_mst (
  input  wire logic        i_clock,
  output logic [5:0]       o_addr,
  output logic             o_write,
  output logic [7:0]       o_be,
  output logic [63:0]      o_data
);
  initial {o_addr, o_write, o_be, o_data} = '0;
  task put(input logic [5:0] a, input logic [7:0] b, input logic [63:0] v);
    @(negedge i_clock);
    {o_addr, o_be, o_data} = {a, b, v};
    o_write = 1'b1;
  endtask
  // released bus shows the inverse so stale data cannot pass
  task idle;
    @(negedge i_clock);
    o_write = 1'b0;
    o_data = ~o_data;
  endtask
endmodule

// ==== tb/icw_write_port_sva.sv ====
`timescale 1ns/100ps
module icw_write_port_sva #(
  parameter int DATA_W = 64, NUM_REGS = 16, CW = 2,
  localparam int AW = CW + 7 - $clog2(DATA_W / 8)
) (
  input wire logic I_CLOCK, I_RSTN, I_WRITE, O_WRITE_SEEN, O_WRITE_DROPPED,
  input wire logic [AW-1:0]       I_ADDRESS,
  input wire logic [DATA_W/8-1:0] I_BYTEENABLE,
  input wire logic [DATA_W-1:0]   I_WRITEDATA,
  input wire logic [CW-1:0]       I_RD_CID,
  input wire logic [3:0]          I_RD_INDEX,
  input wire logic [31:0]         O_RD_WORD
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);
  wire logic [AW-CW-1:0] wi = I_ADDRESS[AW-CW-1:0];
  wire logic inr = 32'(wi) * (DATA_W / 32) < NUM_REGS;
  wire logic hit = I_WRITE && I_RD_CID == I_ADDRESS[AW-1-:CW]
                   && {1'b0, I_RD_INDEX[3:1]} == wi;
  function automatic logic [31:0] sw(logic [31:0] v);
    return {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  a_seen_write: assert property (I_WRITE && inr |=> O_WRITE_SEEN)
    else $error("in-range write gave no pulse");
  a_drop_range: assert property (
    I_WRITE && !inr |=> O_WRITE_DROPPED)
    else $error("out-of-range write not dropped");
  a_idle_quiet: assert property (
    !I_WRITE |=> !O_WRITE_SEEN && !O_WRITE_DROPPED)
    else $error("pulse without write");
  a_pulse_excl: assert property (!(O_WRITE_SEEN && O_WRITE_DROPPED))
    else $error("seen and dropped together");
  a_read_hold: assert property (!I_WRITE ##1 (!I_WRITE &&
    $stable({I_RD_CID, I_RD_INDEX})) |=> $stable(O_RD_WORD))
    else $error("word moved without write");
  a_lane_low: assert property (
    hit && I_RD_INDEX[0] && &I_BYTEENABLE[3:0]
    ##1 $stable({I_RD_CID, I_RD_INDEX})
    |=> O_RD_WORD == sw($past(I_WRITEDATA[31:0], 2)))
    else $error("low lane stored wrong");
  a_lane_high: assert property (
    hit && !I_RD_INDEX[0] && &I_BYTEENABLE[7:4]
    ##1 $stable({I_RD_CID, I_RD_INDEX})
    |=> O_RD_WORD == sw($past(I_WRITEDATA[63:32], 2)))
    else $error("high lane stored wrong");
  a_mask_keep: assert property (hit && I_BYTEENABLE == '0
    ##1 $stable({I_RD_CID, I_RD_INDEX}) |=> $stable(O_RD_WORD))
    else $error("masked write changed word");
endmodule

// ==== tb/icw_write_port_tb.sv ====
`timescale 1ns/100ps
module icw_write_port_tb;
  logic clk = 0, rstn = 0, w, seen, drop;
  logic [1:0] rc = 0;
  logic [3:0] ri = 0;
  logic [5:0] a;
  logic [7:0] be;
  logic [63:0] d;
  logic [31:0] q;
  int bad_count = 0, checks_done = 0;
  initial forever #12.5 clk = ~clk;
  icw_mst u_icw_mst (.i_clock(clk), .o_addr(a), .o_write(w), .o_be(be),
    .o_data(d));
  icw_write_port #(.DATA_W(64)) u_icw_write_port (.I_CLOCK(clk),
    .I_RSTN(rstn), .I_ADDRESS(a), .I_WRITE(w), .I_BYTEENABLE(be),
    .I_WRITEDATA(d), .I_RD_CID(rc), .I_RD_INDEX(ri), .O_RD_WORD(q),
    .O_WRITE_SEEN(seen), .O_WRITE_DROPPED(drop));
  task chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task rd(logic [1:0] c, logic [3:0] i, logic [31:0] e);
    @(negedge clk);
    {rc, ri} = {c, i};
    @(negedge clk);
    chk("word", q, e);
  endtask
  task t_lanes;
    u_icw_mst.put(6'h13, 8'hFF, 64'h0123456789ABCDEF);
    u_icw_mst.idle;
    chk("seen", {31'h0, seen}, 32'h1);
    rd(2'h1, 4'h6, 32'h67452301);
    rd(2'h1, 4'h7, 32'hEFCDAB89);
  endtask
  // back to back, partial and empty enables
  task t_bytes;
    u_icw_mst.put(6'h13, 8'h0F, 64'h11);
    u_icw_mst.put(6'h13, 8'h80, {8'hFF, 56'h0});
    u_icw_mst.put(6'h13, 8'h00, '1);
    u_icw_mst.idle;
    rd(2'h1, 4'h7, 32'h11000000);
    rd(2'h1, 4'h6, 32'h674523FF);
  endtask
  task t_drop;
    u_icw_mst.put(6'h28, 8'hFF, '1);
    u_icw_mst.idle;
    chk("drop", {31'h0, drop}, 32'h1);
    rd(2'h2, 4'h0, 32'h0);
  endtask
  task t_cid;
    u_icw_mst.put(6'h20, 8'hFF, 64'h1122334455667788);
    u_icw_mst.idle;
    rd(2'h2, 4'h1, 32'h88776655);
    rd(2'h3, 4'h0, 32'h0);
  endtask
  task summarize;
    if (bad_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1;
    t_lanes;
    t_bytes;
    t_drop;
    t_cid;
    summarize;
  end
  initial begin
    #5us;
    bad_count++;
    summarize;
  end
endmodule
bind icw_write_port icw_write_port_sva #(.DATA_W(DATA_W),
  .NUM_REGS(NUM_REGS), .CW(CIDW)) u_icw_write_port_sva (.*);
